//--- logic/dmbs_bank_select.sv
// Data-memory bank select: pointer register, indirect port and banked RAM.
// Assumes the core drives a plain register port; special registers other
// than the pointer, timer slot and indirect port live outside and are reached via ext_*.
// RAM comes up undefined; the pointer clears to zero on reset.
//
// Operation
// - The bank pointer is read and written by the core and steers which page indirect port accesses reach; direct addresses carry their own block bits.
// - Pointer bits 7..5 pick one of eight blocks; code 000 is block 0 and even codes show the timer low byte.
// - Odd block codes pick their block and show the timer high byte in the timer slot.
// - Code 111 picks the last block with the timer high byte in the timer slot.
// - With bit 4 clear the lower 16 bytes are reached, shared by all blocks.
// - With bit 4 set the upper 16 bytes of the selected block are reached.
// - Pointer bits 3..0 pick the byte within the selected block or region.
// - The low four bits decode straight to a location, zero being the first.
// - An access to the indirect data port goes to the location held in the pointer.
//
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/100ps
module dmbs_bank_select #(
	parameter int unsigned BLOCKS = dmbs_pkg::BLOCKS
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Core register port
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr_stb,
	input wire logic rd_stb,
	output logic [7:0] rdata,
	// General timer bytes
	input wire logic [15:0] general_timer,
	// Outside special registers, reached for shared locations not held here
	output logic ext_wr,
	output logic ext_rd,
	output logic [3:0] ext_addr,
	output logic [7:0] ext_wdata,
	input wire logic [7:0] ext_rdata
);
	localparam int unsigned RB = dmbs_pkg::REGION_BYTES;
	localparam int unsigned BANK_BYTES = BLOCKS * RB;

	logic [7:0] data_bank_pointer_q, data_bank_pointer_d;
	logic [7:0] rdata_q, rdata_d;
	// Shared lower region and banked upper regions
	logic [7:0] shared_q [RB];
	logic [7:0] shared_d [RB];
	logic [7:0] banked_q [BLOCKS*RB];
	logic [7:0] banked_d [BLOCKS*RB];

	logic [7:0] eff_addr;
	logic [2:0] blk;
	logic [3:0] byte_sel;
	logic upper;
	logic [7:0] mem_rd;
	logic is_shared_ext;

	// Decoded slot and per-byte write enables
	logic hit_timer;
	logic hit_pointer;
	logic hit_self;
	logic hit_shared_ram;
	logic [6:0] bank_index;
	logic [7:0] timer_byte;
	logic [RB-1:0] shared_we;
	logic [BANK_BYTES-1:0] banked_we;

	// Where an access lands once the indirect port is resolved
	typedef enum logic [2:0] {
		SLOT_BANKED,
		SLOT_TIMER,
		SLOT_POINTER,
		SLOT_SELF,
		SLOT_EXT,
		SLOT_SHARED
	} dmbs_slot_type;
	dmbs_slot_type slot;

	// Indirect port resolves to the pointer contents
	always_comb begin
		if (addr == dmbs_pkg::INDIRECT_OFFSET) begin
			eff_addr = data_bank_pointer_q;
		end else begin
			eff_addr = addr;
		end
	end

	assign blk = eff_addr[dmbs_pkg::BLOCK_MSB:dmbs_pkg::BLOCK_LSB];
	assign upper = eff_addr[dmbs_pkg::UPPER_BIT];
	assign byte_sel = eff_addr[dmbs_pkg::BYTE_MSB:0];

	// Lower special locations other than indirect port, pointer and timer go outside
	assign is_shared_ext = !upper && (byte_sel < 4'(dmbs_pkg::SHARED_SPECIAL))
		&& (eff_addr[3:0] != dmbs_pkg::TIMER_OFFSET[3:0])
		&& (eff_addr[3:0] != dmbs_pkg::POINTER_OFFSET[3:0])
		&& (eff_addr[3:0] != dmbs_pkg::INDIRECT_OFFSET[3:0]);

	assign ext_addr = byte_sel;
	assign ext_wdata = wdata;
	assign ext_wr = wr_stb && is_shared_ext;
	assign ext_rd = rd_stb && is_shared_ext;

	// Lower-region slot decode
	assign hit_timer = !upper && (byte_sel == dmbs_pkg::TIMER_OFFSET[3:0]);
	assign hit_pointer = !upper && (byte_sel == dmbs_pkg::POINTER_OFFSET[3:0]);
	assign hit_self = !upper && (byte_sel == dmbs_pkg::INDIRECT_OFFSET[3:0]);
	assign hit_shared_ram = !upper && (byte_sel >= 4'(dmbs_pkg::SHARED_SPECIAL));
	assign bank_index = {blk, byte_sel};

	// Slot priority: banked first, then the lower specials
	always_comb begin
		if (upper) begin
			slot = SLOT_BANKED;
		end else if (hit_timer) begin
			slot = SLOT_TIMER;
		end else if (hit_pointer) begin
			slot = SLOT_POINTER;
		end else if (hit_self) begin
			slot = SLOT_SELF;
		end else if (is_shared_ext) begin
			slot = SLOT_EXT;
		end else begin
			slot = SLOT_SHARED;
		end
	end

	// Odd block code shows the high byte, even the low byte
	always_comb begin
		if (blk[0]) begin
			timer_byte = general_timer[15:8];
		end else begin
			timer_byte = general_timer[7:0];
		end
	end

	// One write enable per shared byte; specials never match
	for (genvar gi = 0; gi < RB; gi++) begin : g_shared_we
		assign shared_we[gi] = wr_stb && hit_shared_ram && (byte_sel == 4'(gi));
	end

	// One write enable per banked byte, block code on top
	for (genvar gb = 0; gb < BANK_BYTES; gb++) begin : g_banked_we
		assign banked_we[gb] = wr_stb && upper && (bank_index == 7'(gb));
	end

	// Read mux
	always_comb begin
		unique case (slot)
			SLOT_BANKED: begin
				mem_rd = banked_q[bank_index];
			end
			SLOT_TIMER: begin
				mem_rd = timer_byte;
			end
			SLOT_POINTER: begin
				mem_rd = data_bank_pointer_q;
			end
			SLOT_SELF: begin
				// Indirect through a pointer at itself reads as zero
				mem_rd = 8'h00;
			end
			SLOT_EXT: begin
				mem_rd = ext_rdata;
			end
			SLOT_SHARED: begin
				mem_rd = shared_q[byte_sel];
			end
			default: begin
				mem_rd = 8'h00;
			end
		endcase
	end

	// Pointer next value
	always_comb begin
		data_bank_pointer_d = data_bank_pointer_q;
		if (wr_stb && hit_pointer) begin
			data_bank_pointer_d = wdata;
		end
	end

	// Read data stands one cycle after the strobe, zero otherwise
	always_comb begin
		rdata_d = 8'h00;
		if (rd_stb) begin
			rdata_d = mem_rd;
		end
	end

	// RAM next values from the per-byte enables
	always_comb begin
		for (int i = 0; i < RB; i++) begin
			shared_d[i] = shared_we[i] ? wdata : shared_q[i];
		end
		for (int j = 0; j < BANK_BYTES; j++) begin
			banked_d[j] = banked_we[j] ? wdata : banked_q[j];
		end
	end

	// Pointer clears on reset even though software must set it first
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			data_bank_pointer_q <= dmbs_pkg::POINTER_RESET;
		end else begin
			data_bank_pointer_q <= data_bank_pointer_d;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	// RAM contents are not reset
	always_ff @(posedge clk) begin
		shared_q <= shared_d;
		banked_q <= banked_d;
	end

	assign rdata = rdata_q;
endmodule

//--- logic/dmbs_pkg.sv
// Package for the data-memory bank select block.
// Assumes an 8-bit core datapath and a single core clock.
package dmbs_pkg;
	// Pointer field positions
	localparam int unsigned BLOCK_MSB = 7;
	localparam int unsigned BLOCK_LSB = 5;
	localparam int unsigned UPPER_BIT = 4;
	localparam int unsigned BYTE_MSB = 3;
	// Register-port offsets (address of the indirect port, the timer and the pointer)
	localparam logic [7:0] INDIRECT_OFFSET = 8'h00;
	localparam logic [7:0] TIMER_OFFSET = 8'h01;
	localparam logic [7:0] POINTER_OFFSET = 8'h04;
	// Pointer has no defined power-on value; flops still clear to this
	localparam logic [7:0] POINTER_RESET = 8'h00;
	// Data memory shape
	localparam int unsigned BLOCKS = 8;
	localparam int unsigned REGION_BYTES = 16;
	localparam int unsigned SHARED_SPECIAL = 8;
endpackage

//--- test/dmbs_ext_model.sv
// Outside special registers model.
`timescale 1ns/100ps
module dmbs_ext_model(input wire logic clk,ext_wr,ext_rd,input wire logic [3:0] ext_addr,
	input wire logic [7:0] ext_wdata,output logic [7:0] ext_rdata);
	logic [7:0] r [16]='{default:8'h00};
	assign ext_rdata=ext_rd?r[ext_addr]:~r[ext_addr];
	always @(posedge clk) if (ext_wr) r[ext_addr]<=ext_wdata;
endmodule

//--- test/dmbs_monitor.sv
// Port checker; bound onto the bank select block.
`timescale 1ns/100ps
module dmbs_monitor(input wire logic clk,rst_n,wr_stb,rd_stb,ext_wr,ext_rd,input wire logic [3:0] ext_addr,
	input wire logic [7:0] addr,wdata,rdata,ext_wdata,input wire logic [15:0] general_timer);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence ptr_wr; wr_stb&&addr==8'h04; endsequence
	sequence ptr_rb; ptr_wr ##1 !wr_stb ##1 rd_stb&&addr==8'h04; endsequence
	ptr_back_a: assert property (ptr_rb |=> rdata==$past(wdata,3)) else $error("ptr");
	tmr_lo_a: assert property (rd_stb&&addr[5:0]==6'h01 |=> rdata==$past(general_timer[7:0])) else $error("lo");
	tmr_hi_a: assert property (rd_stb&&addr[5:0]==6'h21 |=> rdata==$past(general_timer[15:8])) else $error("hi");
	shared_ext_a: assert property (rd_stb&&addr[4:0]==5'h05 |-> ext_rd&&ext_addr==4'h5) else $error("shr");
	bank_ram_a: assert property ((wr_stb||rd_stb)&&addr[4] |-> !ext_wr&&!ext_rd) else $error("bank");
	byte_sel_a: assert property ((ext_wr||ext_rd)&&addr!=8'h00 |-> ext_addr==addr[3:0]) else $error("byte");
	loc_sel_a: assert property (wr_stb&&addr==8'h02 |-> ext_wr&&ext_addr==4'h2&&ext_wdata==wdata) else $error("loc");
	ind_rd_a: assert property (ptr_wr ##0 wdata==8'h06 ##1 rd_stb&&!addr|->ext_rd&&ext_addr==4'h6) else $error("i");
endmodule
bind dmbs_bank_select dmbs_monitor mon(.*);

//--- test/data_memory_bank_select_tb_top.sv
// Random bench against a reference model; assumes the checker is bound in.
`timescale 1ns/100ps
module data_memory_bank_select_tb_top;
	logic clk=0,rst_n=1,wr_stb=0,rd_stb=0,ext_wr,ext_rd;
	logic [7:0] addr=8'h00,wdata=8'h00,rdata,ext_wdata,ext_rdata,p,a;
	logic [15:0] general_timer=16'h0000;
	logic [3:0] ext_addr;
	int num_errors=0,cmp_count=0,seed=32'hebd84c10,exp=0,k,i,m[int],ex[16];
	dmbs_bank_select dut(.*);
	dmbs_ext_model far(.*);
	always #25 clk=~clk;
	task test_done(input int late);
		num_errors+=late;
		if (num_errors==0&&cmp_count>0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// Mode 1 writes, mode 2 reads, others idle
	task op(input logic [1:0] md,input logic [7:0] ad,d);
		@(posedge clk);
		{wr_stb,rd_stb,addr,wdata}<={md==2'h1,md==2'h2,ad,d};
		general_timer<=16'($random(seed));
	endtask
	task chk(input logic [7:0] got,input int want);
		cmp_count++;
		if (got!==want[7:0]) num_errors++;
		if (got!==want[7:0]) $display("ERROR rdata exp %h got %h",want[7:0],got);
	endtask
	// Unwritten RAM reads are skipped
	always @(posedge clk) begin
		if (exp>=0) chk(rdata,exp);
		a=addr?addr:p;
		k=a[4]?a:a[3:0];
		exp=!rd_stb?0:k==1?general_timer[a[5]*8+:8]:k==4?p:k<8?ex[k]:m.exists(k)?m[k]:-1;
		if (wr_stb&&k==4) p=wdata;
		else if (wr_stb&&k>7) m[k]=wdata;
		else if (wr_stb&&k>1) ex[k]=wdata;
		if (!rst_n) p=0;
	end
	initial begin
		rst_n<=1'b0;
		repeat (20) @(posedge clk);
		rst_n<=1;
		op(2'h1,8'h04,8'h06);
		op(2'h2,8'h00,8'h00);
		op(2'h2,8'h04,8'h00);
		for (i=0;i<8;i++) op(2'h2,{i[2:0],5'h01},8'h00);
		for (i=0;i<6000;i++) op(2'($random(seed)),8'($random(seed)),8'($random(seed)));
		op(2'h0,8'h00,8'h00);
		repeat (2) @(negedge clk);
		test_done(0);
	end
	initial #400000 test_done(1);
endmodule
